// >>> design/stc_chan_table.sv
// Presence map of channels known on the field bus
`timescale 1ns/10ps
module stc_chan_table
  import stc_pkg::*;
#(
  parameter int NUM_CHAN = 31
)
(
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic                clr_all,
  input  wire logic                wr_en,
  input  wire logic [CHAN_W-1:0]   wr_idx,
  input  wire logic                wr_val,
  output logic      [DATA_W-1:0]   map
);

  logic [DATA_W-1:0] map_reg;

  // ----------------------------------------------------------------------
  // One flag per channel; bit 0 and unused bits stay zero
  // ----------------------------------------------------------------------
  assign map_reg[0] = 1'b0;

  genvar g;
  generate
    for (g = 1; g < DATA_W; g++)
    begin : g_bit
      if (g <= NUM_CHAN)
      begin : g_used
        // Only a clear, a scan or a bus answer for the current channel changes a flag
        always_ff @(posedge clk_sys)
        begin
          if (rst)
            map_reg[g] <= 1'b0;
          else if (ce)
          begin
            if (clr_all)
              map_reg[g] <= 1'b0;
            else if (wr_en && wr_idx == CHAN_W'(g))
              map_reg[g] <= wr_val;
          end
        end
      end
      else
      begin : g_unused
        assign map_reg[g] = 1'b0;
      end
    end
  endgenerate

  assign map = map_reg;

endmodule : stc_chan_table

// >>> design/stc_cmd_interp.sv
// Command interpreter: sequencing, arming, channel select and readback
`timescale 1ns/10ps
module stc_cmd_interp
  import stc_pkg::*;
#(
  parameter int NUM_CHAN = 31
)
(
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic          ce,
  input  wire logic          cmd_valid,
  input  wire stc_cmd_t      cmd,
  output logic               cmd_ready,
  input  wire logic          get_msg,
  input  wire logic          dev_clear,
  input  wire logic          out_busy,
  output logic               fb_req_valid,
  output stc_fb_req_t        fb_req,
  input  wire logic          fb_done,
  input  wire stc_fb_rsp_t   fb_rsp,
  output logic               rsp_valid,
  output stc_rsp_t           rsp,
  output logic               err_valid,
  output logic [15:0]        err_code,
  output logic               ques_warn,
  output logic               wtg,
  output logic               cont_on
);

  typedef enum logic [2:0] {
    S_IDLE,
    S_WAIT_CONT,
    S_FB_WAIT,
    S_SCAN_REQ,
    S_SCAN_WAIT
  } stc_state_t;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  stc_state_t          state_reg;
  stc_state_t          state_next;
  stc_op_t             cur_op_reg;
  logic [CHAN_W-1:0]   cur_chan_reg;
  logic [CHAN_W-1:0]   sel_reg;
  logic [CHAN_W-1:0]   scan_reg;
  logic                get_pend_reg;
  logic                get_pend_next;
  logic                cmd_ready_reg;
  logic                fb_req_valid_reg;
  stc_fb_req_t         fb_req_reg;
  logic                rsp_valid_reg;
  stc_rsp_t            rsp_reg;
  logic                err_valid_reg;
  logic [15:0]         err_code_reg;
  logic                ques_warn_reg;

  logic                armed;
  logic                cont;
  logic [DATA_W-1:0]   cat_map;

  // Resolve the channel a command acts on
  function automatic logic [CHAN_W-1:0] target_of(
    input logic [CHAN_W-1:0] req_chan,
    input logic [CHAN_W-1:0] sel_chan
  );
    target_of = (req_chan == CHAN_NONE) ? sel_chan : req_chan;
  endfunction : target_of

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  // Commands are taken one at a time, strictly in order
  wire               idle      = (state_reg == S_IDLE);
  wire               take      = idle && cmd_valid && cmd_ready_reg;
  wire [CHAN_W-1:0]  tgt       = target_of(cmd.chan, sel_reg);
  wire               is_trg    = take && cmd.op == OP_TRIGGER;
  wire               is_rst    = take && cmd.op == OP_RESET;
  wire               is_sel    = take && (cmd.op == OP_SELECT ||
                                          cmd.op == OP_NUM_SELECT);
  wire               sel_ok    = cmd.chan >= CHAN_MIN &&
                                 cmd.chan <= CHAN_MAX;
  wire               is_state  = take && cmd.op == OP_INST_STATE;
  wire               is_meas   = take && cmd.op == OP_MEAS_CURR_Q;
  // A bus GET waits in idle; it is served ahead of the next command
  wire               get_go    = idle && get_pend_reg;
  wire               trig_in   = get_go || is_trg;
  wire               trig_fire = trig_in && (armed || cont);
  // Nothing left in flight: no level change, no shot still armed
  wire               all_done  = !out_busy && !get_pend_reg &&
                                 !(armed && !cont);
  wire               fb_ok     = fb_done && fb_rsp.present;
  wire               scan_last = (scan_reg == CHAN_MAX);

  // GET is remembered; a new GET in the serving cycle is kept
  assign get_pend_next = get_msg || (get_pend_reg && !get_go);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:
      begin
        if (trig_fire)
          state_next = S_FB_WAIT;
        else if (take)
        begin
          case (cmd.op)
            OP_WAIT_CONT:   state_next = S_WAIT_CONT;
            OP_RESET:       state_next = S_SCAN_REQ;
            OP_SELECT,
            OP_NUM_SELECT:  state_next = sel_ok ? S_FB_WAIT : S_IDLE;
            OP_INST_STATE,
            OP_MEAS_CURR_Q: state_next = S_FB_WAIT;
            default:        state_next = S_IDLE;
          endcase
        end
      end
      // Only device clear breaks the wait early
      S_WAIT_CONT:
        if (dev_clear || all_done)
          state_next = S_IDLE;
      S_FB_WAIT:
        if (fb_done)
          state_next = S_IDLE;
      S_SCAN_REQ:
        state_next = S_SCAN_WAIT;
      S_SCAN_WAIT:
        if (fb_done)
          state_next = scan_last ? S_IDLE : S_SCAN_REQ;
      default:
        state_next = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // Sequencer state and selection
  // ----------------------------------------------------------------------
  // Selection persists until another valid select or a reset
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_reg     <= S_IDLE;
      cur_op_reg    <= OP_NOP;
      cur_chan_reg  <= CHAN_DEFAULT;
      sel_reg       <= CHAN_DEFAULT;
      scan_reg      <= CHAN_MIN;
      get_pend_reg  <= 1'b0;
      cmd_ready_reg <= 1'b0;
    end
    else if (ce)
    begin
      state_reg     <= state_next;
      get_pend_reg  <= get_pend_next;
      cmd_ready_reg <= (state_next == S_IDLE) && !get_pend_next;
      if (trig_fire)
      begin
        cur_op_reg   <= OP_TRIGGER;
        cur_chan_reg <= sel_reg;
      end
      else if (take)
      begin
        cur_op_reg   <= cmd.op;
        cur_chan_reg <= is_sel ? cmd.chan : tgt;
      end
      if (is_sel && sel_ok)
        sel_reg <= cmd.chan;
      if (is_rst)
      begin
        sel_reg  <= CHAN_DEFAULT;
        scan_reg <= CHAN_MIN;
      end
      else if (state_reg == S_SCAN_WAIT && fb_done && !scan_last)
        scan_reg <= scan_reg + 5'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Field bus requests
  // ----------------------------------------------------------------------
  // One request per operation, one per channel for the reset scan; the answer is awaited before moving on
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      fb_req_valid_reg <= 1'b0;
      fb_req_reg       <= '{op: FB_PROBE, chan: CHAN_NONE};
    end
    else if (ce)
    begin
      fb_req_valid_reg <= 1'b0;
      if (trig_fire)
      begin
        fb_req_valid_reg <= 1'b1;
        fb_req_reg       <= '{op: FB_TRIG_APPLY, chan: sel_reg};
      end
      else if (is_sel && sel_ok)
      begin
        fb_req_valid_reg <= 1'b1;
        fb_req_reg       <= '{op: FB_PROBE, chan: cmd.chan};
      end
      else if (is_state)
      begin
        fb_req_valid_reg <= 1'b1;
        fb_req_reg.op    <= cmd.arg ? FB_OUT_ON : FB_OUT_OFF;
        fb_req_reg.chan  <= tgt;
      end
      else if (is_meas)
      begin
        fb_req_valid_reg <= 1'b1;
        fb_req_reg       <= '{op: FB_MEAS_CURR, chan: tgt};
      end
      else if (state_reg == S_SCAN_REQ)
      begin
        fb_req_valid_reg <= 1'b1;
        fb_req_reg       <= '{op: FB_INIT, chan: scan_reg};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Answers, errors and warning
  // ----------------------------------------------------------------------
  // Catalog answers from the stored map, no bus traffic at all
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rsp_valid_reg <= 1'b0;
      rsp_reg       <= '{kind: RSP_INT, value: ANS_ZERO};
      err_valid_reg <= 1'b0;
      err_code_reg  <= ERR_NONE;
      ques_warn_reg <= 1'b0;
    end
    else if (ce)
    begin
      rsp_valid_reg <= 1'b0;
      err_valid_reg <= 1'b0;
      ques_warn_reg <= is_meas && cmd.extra;
      if (take && cmd.op == OP_INIT_CONT_Q)
      begin
        rsp_valid_reg <= 1'b1;
        rsp_reg       <= '{kind: RSP_INT,
                           value: cont ? ANS_ONE : ANS_ZERO};
      end
      else if (take && cmd.op == OP_CATALOG_Q)
      begin
        rsp_valid_reg <= 1'b1;
        rsp_reg       <= '{kind: RSP_CATALOG, value: cat_map};
      end
      else if (take && cmd.op == OP_SELECT_Q)
      begin
        rsp_valid_reg <= 1'b1;
        rsp_reg       <= '{kind: RSP_INT,
                           value: {27'h0000000, sel_reg}};
      end
      else if (state_reg == S_FB_WAIT && fb_ok &&
               cur_op_reg == OP_MEAS_CURR_Q)
      begin
        rsp_valid_reg <= 1'b1;
        rsp_reg       <= '{kind: RSP_MEAS, value: fb_rsp.data};
      end
      if (state_reg == S_FB_WAIT && fb_done && !fb_rsp.present)
      begin
        err_valid_reg <= 1'b1;
        err_code_reg  <= ERR_HW_NOT_FOUND;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  // Addressed answers update the map; absence drops, return restores
  wire tbl_wr = fb_done && (state_reg == S_FB_WAIT ||
                            state_reg == S_SCAN_WAIT);
  wire [CHAN_W-1:0] tbl_idx = (state_reg == S_SCAN_WAIT) ? scan_reg
                                                         : cur_chan_reg;

  stc_chan_table #(
    .NUM_CHAN (NUM_CHAN)
  ) u_table (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ce       (ce),
    .clr_all  (is_rst),
    .wr_en    (tbl_wr),
    .wr_idx   (tbl_idx),
    .wr_val   (fb_rsp.present),
    .map      (cat_map)
  );

  stc_trig_arm u_trig (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .ce        (ce),
    .init_imm  (take && cmd.op == OP_INIT_IMM),
    .cont_wr   (take && cmd.op == OP_INIT_CONT),
    .cont_val  (cmd.arg),
    .reset_cmd (is_rst),
    .trig_in   (trig_in),
    .armed     (armed),
    .cont      (cont),
    .wtg       (wtg)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign cmd_ready    = cmd_ready_reg;
  assign fb_req_valid = fb_req_valid_reg;
  assign fb_req       = fb_req_reg;
  assign rsp_valid    = rsp_valid_reg;
  assign rsp          = rsp_reg;
  assign err_valid    = err_valid_reg;
  assign err_code     = err_code_reg;
  assign ques_warn    = ques_warn_reg;
  assign cont_on      = cont;

endmodule : stc_cmd_interp

// >>> design/stc_pkg.sv
// Shared types and constants for the trigger and channel-select interpreter
package stc_pkg;

  // ----------------------------------------------------------------------
  // Widths and channel range
  // ----------------------------------------------------------------------
  localparam int          CHAN_W       = 5;
  localparam int          DATA_W       = 32;
  localparam logic [4:0]  CHAN_NONE    = 5'h00;  // Use selected channel
  localparam logic [4:0]  CHAN_MIN     = 5'h01;
  localparam logic [4:0]  CHAN_MAX     = 5'h1F;
  localparam logic [4:0]  CHAN_DEFAULT = 5'h01;

  // ----------------------------------------------------------------------
  // Error codes and answer values
  // ----------------------------------------------------------------------
  localparam logic [15:0] ERR_NONE         = 16'h0000;
  localparam logic [15:0] ERR_HW_NOT_FOUND = 16'hFF10;  // -240
  localparam logic [31:0] ANS_ZERO         = 32'h0000_0000;
  localparam logic [31:0] ANS_ONE          = 32'h0000_0001;

  // ----------------------------------------------------------------------
  // Host command opcodes, already parsed from the message stream
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP,
    OP_WAIT_CONT,
    OP_INIT_IMM,
    OP_INIT_CONT,
    OP_INIT_CONT_Q,
    OP_TRIGGER,
    OP_RESET,
    OP_CATALOG_Q,
    OP_SELECT,
    OP_NUM_SELECT,
    OP_SELECT_Q,
    OP_INST_STATE,
    OP_MEAS_CURR_Q
  } stc_op_t;

  // Field bus operations toward the channel supplies
  typedef enum logic [2:0] {
    FB_INIT,       // Probe and set 0 V, 0 A, voltage mode
    FB_PROBE,      // Probe only, brings a supply on-line
    FB_TRIG_APPLY, // Move output to stored triggered values
    FB_OUT_OFF,    // Save levels and drive output to zero
    FB_OUT_ON,     // Restore saved levels
    FB_MEAS_CURR   // Read back terminal current
  } stc_fb_op_t;

  // Kind of answer returned to the host formatter
  typedef enum logic [1:0] {
    RSP_INT,       // Plain integer
    RSP_CATALOG,   // Bitmap, formatter prints comma list
    RSP_MEAS       // Measured value, formatter prints mantissa/exponent
  } stc_rsp_kind_t;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    stc_op_t             op;
    logic [CHAN_W-1:0]   chan;   // CHAN_NONE means selected channel
    logic                arg;    // Boolean argument
    logic                extra;  // Range/accuracy fields followed a query
  } stc_cmd_t;

  typedef struct packed {
    stc_fb_op_t          op;
    logic [CHAN_W-1:0]   chan;
  } stc_fb_req_t;

  typedef struct packed {
    logic                present;
    logic [DATA_W-1:0]   data;
  } stc_fb_rsp_t;

  typedef struct packed {
    stc_rsp_kind_t       kind;
    logic [DATA_W-1:0]   value;
  } stc_rsp_t;

endpackage : stc_pkg

// >>> design/stc_trig_arm.sv
// Trigger arming unit: single-shot and continuous arming
`timescale 1ns/10ps
module stc_trig_arm
  import stc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic init_imm,
  input  wire logic cont_wr,
  input  wire logic cont_val,
  input  wire logic reset_cmd,
  input  wire logic trig_in,
  output logic      armed,
  output logic      cont,
  output logic      wtg
);

  logic armed_reg;
  logic armed_next;
  logic cont_reg;
  logic cont_next;
  logic wtg_reg;

  // ----------------------------------------------------------------------
  // Arming decode
  // ----------------------------------------------------------------------
  // Continuous arming overrides a consumed shot, so rearm at once
  assign cont_next  = reset_cmd ? 1'b0
                    : cont_wr   ? cont_val : cont_reg;
  assign armed_next = reset_cmd ? 1'b0
                    : init_imm  ? 1'b1
                    : trig_in   ? cont_reg
                    : armed_reg;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // Waiting-for-trigger shows armed or permanently armed
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      armed_reg <= 1'b0;
      cont_reg  <= 1'b0;
      wtg_reg   <= 1'b0;
    end
    else if (ce)
    begin
      armed_reg <= armed_next;
      cont_reg  <= cont_next;
      wtg_reg   <= armed_next | cont_next;
    end
  end

  assign armed = armed_reg;
  assign cont  = cont_reg;
  assign wtg   = wtg_reg;

endmodule : stc_trig_arm

// >>> dv/stc_cmd_interp_checker.sv
// Port checker for the command interpreter
`timescale 1ns/10ps
module stc_cmd_interp_checker
  import stc_pkg::*;
#(
  parameter int NUM_CHAN = 31
)
(
  input wire logic         clk_sys,
  input wire logic         rst,
  input wire logic         ce,
  input wire logic         cmd_valid,
  input wire stc_cmd_t     cmd,
  input wire logic         cmd_ready,
  input wire logic         dev_clear,
  input wire logic         out_busy,
  input wire logic         fb_req_valid,
  input wire stc_fb_req_t  fb_req,
  input wire logic         fb_done,
  input wire stc_fb_rsp_t  fb_rsp,
  input wire logic         rsp_valid,
  input wire stc_rsp_t     rsp,
  input wire logic         ques_warn,
  input wire logic         wtg,
  input wire logic         cont_on,
  input wire logic         err_valid,
  input wire logic [15:0]  err_code
);
  // ---------------------------------------------
  // Accepted commands and the answers they cause
  // ---------------------------------------------
  wire take;
  assign take = ce && cmd_valid && cmd_ready;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_meas_req: assert property (
    take && cmd.op == OP_MEAS_CURR_Q |=> fb_req_valid
    && fb_req.op == FB_MEAS_CURR) else $error("measure not sent");
  chk_meas_warn: assert property (
    take && cmd.op == OP_MEAS_CURR_Q |=> ques_warn == $past(cmd.extra))
    else $error("warning bit wrong");
  chk_cont_query: assert property (
    take && cmd.op == OP_INIT_CONT_Q |=> rsp_valid
    && rsp.value == {31'h0, $past(cont_on)}) else $error("bad cont answer");
  chk_reset_cont: assert property (
    take && cmd.op == OP_RESET |=> !cont_on) else $error("cont kept");
  // One cycle of slack, though the flag and the armed level land on the same edge
  chk_cont_armed: assert property (
    cont_on && $past(cont_on) |-> wtg) else $error("cont not armed");
  chk_no_probe: assert property (
    take && cmd.op == OP_CATALOG_Q |=> rsp_valid && !fb_req_valid
    ##1 !fb_req_valid) else $error("catalog probed");
  chk_err_cause: assert property (
    err_valid |-> err_code == ERR_HW_NOT_FOUND
    && $past(fb_done && !fb_rsp.present)) else $error("bad error post");
  chk_trig_apply: assert property (
    take && cmd.op == OP_TRIGGER && wtg |-> ##[1:2] (fb_req_valid
    && fb_req.op == FB_TRIG_APPLY)) else $error("trigger not applied");
  chk_trig_drop: assert property (
    take && cmd.op == OP_TRIGGER && !wtg && !cont_on |=> !fb_req_valid
    ##1 !fb_req_valid) else $error("stale trigger used");
  chk_one_shot: assert property (
    fb_req_valid && fb_req.op == FB_TRIG_APPLY && !cont_on |=> !wtg)
    else $error("still armed after shot");
  chk_wait_hold: assert property (
    take && cmd.op == OP_WAIT_CONT ##1 (out_busy && !dev_clear)[*2]
    |-> !cmd_ready) else $error("wait released early");

  cover property (take && cmd.op == OP_MEAS_CURR_Q);
  cover property (fb_req_valid && fb_req.op == FB_TRIG_APPLY);
  cover property (err_valid);
endmodule : stc_cmd_interp_checker

bind stc_cmd_interp stc_cmd_interp_checker #(.NUM_CHAN(NUM_CHAN)) u_chk (
  .clk_sys, .rst, .ce, .cmd_valid, .cmd, .cmd_ready, .dev_clear,
  .out_busy, .fb_req_valid, .fb_req, .fb_done, .fb_rsp, .rsp_valid,
  .rsp, .ques_warn, .wtg, .cont_on, .err_valid, .err_code
);

// >>> dv/stc_cmd_interp_test.sv
// Self-checking bench for the command interpreter
`timescale 1ns/10ps
`define STC_CHECK(a, b) \
  begin \
    n_compared++; \
    if ((a) !== (b)) \
    begin \
      err_total++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); \
    end \
  end
module stc_cmd_interp_test
  import stc_pkg::*;
();
  typedef struct packed {
    stc_op_t     op;
    logic [4:0]  chan;
    logic        arg;
    logic [3:0]  pres;
    logic [1:0]  ans;
    logic [15:0] exp_val;
  } stc_row_t;
  localparam int NROW = 18;
  logic clk_sys, rst, ce, cmd_valid, cmd_ready, get_msg, dev_clear;
  logic out_busy, fb_req_valid, fb_done, rsp_valid, err_valid, ques_warn;
  logic wtg, cont_on;
  logic [15:0] err_code;
  logic [31:0] pres, got;
  logic [3:0]  lat;
  stc_cmd_t    cmd;
  stc_fb_req_t fb_req;
  stc_fb_rsp_t fb_rsp;
  stc_rsp_t    rsp;
  stc_fb_op_t  last_op;
  int          err_total = 0, n_compared = 0, n_trig = 0, n_warn = 0;
  // Ordinary cases: answer kind 1 = rsp, 2 = error, 0 = none
  stc_row_t rows [NROW] = '{
    '{OP_RESET,       5'h00, 1'b0, 4'hE, 2'h0, 16'h0000},
    '{OP_CATALOG_Q,   5'h00, 1'b0, 4'hE, 2'h1, 16'h000E},
    '{OP_INIT_CONT,   5'h00, 1'b1, 4'hE, 2'h0, 16'h0000},
    '{OP_INIT_CONT_Q, 5'h00, 1'b0, 4'hE, 2'h1, 16'h0001},
    '{OP_SELECT,      5'h03, 1'b0, 4'hE, 2'h0, 16'h0000},
    '{OP_SELECT_Q,    5'h00, 1'b0, 4'hE, 2'h1, 16'h0003},
    '{OP_NUM_SELECT,  5'h02, 1'b0, 4'hE, 2'h0, 16'h0000},
    '{OP_SELECT_Q,    5'h00, 1'b0, 4'hE, 2'h1, 16'h0002},
    '{OP_SELECT,      5'h00, 1'b0, 4'hE, 2'h0, 16'h0000},
    '{OP_SELECT_Q,    5'h00, 1'b0, 4'hE, 2'h1, 16'h0002},
    '{OP_MEAS_CURR_Q, 5'h00, 1'b0, 4'hE, 2'h1, 16'h0002},
    '{OP_MEAS_CURR_Q, 5'h05, 1'b0, 4'hE, 2'h2, 16'hFF10},
    '{OP_CATALOG_Q,   5'h00, 1'b0, 4'hA, 2'h1, 16'h000E},
    '{OP_MEAS_CURR_Q, 5'h02, 1'b0, 4'hA, 2'h2, 16'hFF10},
    '{OP_CATALOG_Q,   5'h00, 1'b0, 4'hE, 2'h1, 16'h000A},
    '{OP_SELECT,      5'h02, 1'b0, 4'hE, 2'h0, 16'h0000},
    '{OP_CATALOG_Q,   5'h00, 1'b0, 4'hE, 2'h1, 16'h000E},
    '{OP_RESET,       5'h00, 1'b0, 4'hE, 2'h0, 16'h0000}
  };

  stc_cmd_interp #(.NUM_CHAN(31)) u_dut (
    .clk_sys, .rst, .ce, .cmd_valid, .cmd, .cmd_ready, .get_msg,
    .dev_clear, .out_busy, .fb_req_valid, .fb_req, .fb_done, .fb_rsp,
    .rsp_valid, .rsp, .err_valid, .err_code, .ques_warn, .wtg, .cont_on
  );
  stc_fb_model u_fb (
    .clk_sys, .rst, .fb_req_valid, .fb_req, .pres, .lat, .fb_done, .fb_rsp
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Tally trigger applications, warnings and the last bus operation
  always @(posedge clk_sys)
  begin
    if (fb_req_valid === 1'b1 && fb_req.op == FB_TRIG_APPLY) n_trig++;
    if (ques_warn === 1'b1) n_warn++;
    if (fb_req_valid === 1'b1) last_op = fb_req.op;
  end

  task automatic final_report;
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  // Hold the command until cmd_ready is seen high (taken only if ce is high), then await the answer kind asked for
  task automatic issue(input stc_op_t op, input logic [4:0] ch,
                       input logic arg, input logic ex, input logic [1:0] ans);
    int i;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd       <= '{op, ch, arg, ex};
    @(posedge clk_sys);
    for (i = 0; i < 2000 && cmd_ready !== 1'b1; i++) @(posedge clk_sys);
    cmd_valid <= 1'b0;
    for (i = i; ans != 2'h0 && i < 2000; i++)
    begin
      @(posedge clk_sys);
      if ((ans == 2'h1 && rsp_valid === 1'b1) || (ans == 2'h2
          && err_valid === 1'b1)) break;
    end
    got = (ans == 2'h1) ? rsp.value : {16'h0, err_code};
    if (i >= 2000)
    begin
      err_total++;
      final_report();
    end
  endtask : issue

  task automatic pulse_get;
    get_msg <= 1'b1;
    @(posedge clk_sys);
    get_msg <= 1'b0;
    repeat (20) @(posedge clk_sys);
  endtask : pulse_get

  initial
  begin
    {rst, ce} = 2'h3;
    {cmd_valid, get_msg, dev_clear, out_busy} = 4'h0;
    cmd = '0;
    pres = 32'h0;
    lat = 4'h0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    for (int r = 0; r < NROW; r++)
    begin
      pres <= {28'h0, rows[r].pres};
      issue(rows[r].op, rows[r].chan, rows[r].arg, 1'b0, rows[r].ans);
      if (rows[r].ans != 2'h0)
        `STC_CHECK(got, {16'h0, rows[r].exp_val})
    end
    issue(OP_INIT_CONT_Q, 5'h00, 1'b0, 1'b0, 2'h1);
    `STC_CHECK(got, 32'h0000_0000)
    lat <= 4'h6;
    for (int k = 0; k < 2; k++)
    begin
      issue(OP_INST_STATE, 5'h00, k[0], 1'b0, 2'h0);
      issue(OP_SELECT_Q, 5'h00, 1'b0, 1'b0, 2'h1);
      `STC_CHECK(last_op, k ? FB_OUT_ON : FB_OUT_OFF)
      `STC_CHECK(fb_req.chan, 5'h01)
    end
    issue(OP_MEAS_CURR_Q, 5'h00, 1'b0, 1'b1, 2'h1);
    `STC_CHECK(got, 32'h0000_0001)
    `STC_CHECK(rsp.kind, RSP_MEAS)
    `STC_CHECK(n_warn, 1)
    // Single shot: one trigger served, later ones dropped
    issue(OP_INIT_IMM, 5'h00, 1'b0, 1'b0, 2'h0);
    repeat (2) @(posedge clk_sys);
    `STC_CHECK(wtg, 1'b1)
    pulse_get();
    `STC_CHECK(n_trig, 1)
    `STC_CHECK(wtg, 1'b0)
    pulse_get();
    issue(OP_TRIGGER, 5'h00, 1'b0, 1'b0, 2'h0);
    repeat (12) @(posedge clk_sys);
    `STC_CHECK(n_trig, 1)
    // Continuous: every trigger served, stays armed
    issue(OP_INIT_CONT, 5'h00, 1'b1, 1'b0, 2'h0);
    issue(OP_INIT_IMM, 5'h00, 1'b0, 1'b0, 2'h0);
    issue(OP_TRIGGER, 5'h00, 1'b0, 1'b0, 2'h0);
    issue(OP_TRIGGER, 5'h00, 1'b0, 1'b0, 2'h0);
    issue(OP_INIT_CONT_Q, 5'h00, 1'b0, 1'b0, 2'h1);
    `STC_CHECK(got, 32'h0000_0001)
    `STC_CHECK(n_trig, 3)
    `STC_CHECK(wtg, 1'b1)
    // Wait behind a busy output, then behind an armed shot
    out_busy <= 1'b1;
    issue(OP_WAIT_CONT, 5'h00, 1'b0, 1'b0, 2'h0);
    repeat (5) @(posedge clk_sys);
    `STC_CHECK(cmd_ready, 1'b0)
    out_busy <= 1'b0;
    issue(OP_SELECT_Q, 5'h00, 1'b0, 1'b0, 2'h1);
    `STC_CHECK(got, 32'h0000_0001)
    issue(OP_INIT_CONT, 5'h00, 1'b0, 1'b0, 2'h0);
    issue(OP_INIT_IMM, 5'h00, 1'b0, 1'b0, 2'h0);
    issue(OP_WAIT_CONT, 5'h00, 1'b0, 1'b0, 2'h0);
    repeat (5) @(posedge clk_sys);
    `STC_CHECK(cmd_ready, 1'b0)
    dev_clear <= 1'b1;
    @(posedge clk_sys);
    dev_clear <= 1'b0;
    issue(OP_SELECT_Q, 5'h00, 1'b0, 1'b0, 2'h1);
    `STC_CHECK(got, 32'h0000_0001)
    // Mid-run reset, then a command offered while ce is low is lost
    issue(OP_INIT_CONT, 5'h00, 1'b1, 1'b0, 2'h0);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    `STC_CHECK(wtg, 1'b0)
    ce <= 1'b0;
    issue(OP_INIT_CONT, 5'h00, 1'b1, 1'b0, 2'h0);
    ce <= 1'b1;
    issue(OP_INIT_CONT_Q, 5'h00, 1'b0, 1'b0, 2'h1);
    `STC_CHECK(got, 32'h0000_0000)
    final_report();
  end
endmodule : stc_cmd_interp_test

// >>> dv/stc_fb_model.sv
// Field bus supply model that answers interpreter requests
`timescale 1ns/10ps
module stc_fb_model
  import stc_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         fb_req_valid,
  input  wire stc_fb_req_t  fb_req,
  input  wire logic [31:0]  pres,
  input  wire logic [3:0]   lat,
  output logic              fb_done,
  output stc_fb_rsp_t       fb_rsp
);
  logic [3:0]        cnt_reg;
  logic              busy_reg;
  logic [CHAN_W-1:0] chan_reg;

  // Answer lat+1 cycles after a request is taken; between answers the bus shows junk so a
  // design that samples it outside fb_done sees changing values
  always_ff @(posedge clk_sys)
  begin
    fb_done <= 1'b0;
    fb_rsp  <= ~fb_rsp;
    if (rst)
    begin
      busy_reg <= 1'b0;
      fb_rsp   <= '0;
    end
    else if (fb_req_valid)
    begin
      busy_reg <= 1'b1;
      cnt_reg  <= lat;
      chan_reg <= fb_req.chan;
    end
    else if (busy_reg && cnt_reg != 4'h0)
      cnt_reg <= cnt_reg - 4'h1;
    else if (busy_reg)
    begin
      busy_reg <= 1'b0;
      fb_done  <= 1'b1;
      fb_rsp   <= {pres[chan_reg], 27'h0, chan_reg}; // Current = chan
    end
  end
endmodule : stc_fb_model
